// file: dv/dac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side bus master: single word transfers only
module dac_host_model (
  // Clock
  input wire logic hclk,
  // Request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Answer
  input wire logic hreadyout,
  input wire logic [31:0] hrdata
);
  // Idle bus from time zero
  initial
  begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Ready is looked at before the edge so the edge itself sees it
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(negedge hclk); while (hreadyout !== 1'h1);
    @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
    @(posedge hclk);
  endtask
  task automatic load(input logic [31:0] d[$]);
    logic [31:0] q;
    foreach (d[i]) xfer(1'h1, dac_seq_pkg::DATA_OFS, d[i], q);
  endtask
endmodule // dac_host_model
`default_nettype wire

// file: dv/dac_output_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module dac_output_sequencer_test;
  // Clock, reset, 48/125 reference pulses
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic ref_tick = 1'h0;
  logic [6:0] acc = 7'h0;
  // Bus and outputs
  logic hsel, hwrite, hreadyout, hresp, ao_update, underrun_evt;
  logic ai_start, led_amber, led_green;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, ao0, ao1, q, v;
  logic [7:0] dout;
  // Expected sets and counters
  logic [71:0] exp_q[$];
  logic [31:0] w[$];
  int bad_count = 0;
  int total_checks = 0;
  int n = 0;
  int uf = 0;
  int ai = 0;
  dac_host_model host_u (.hclk(hclk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata));
  dac_output_sequencer #(.ADDR_W(6), .DIO_W(8)) dut_u (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ref_tick(ref_tick), .ext_trig(1'h0), .sync_trig(1'h0), .ao0(ao0),
    .ao1(ao1), .dout(dout), .ao_update(ao_update),
    .underrun_evt(underrun_evt), .ai_start(ai_start),
    .led_amber(led_amber), .led_green(led_green));
  always #4 hclk = ~hclk;
  // Fractional divider stands in for the reference clock
  always @(posedge hclk)
  begin
    ref_tick <= (acc >= 7'h4D);
    acc <= (acc >= 7'h4D) ? acc - 7'h4D : acc + 7'h30;
  end
  task automatic chk(input string s, input logic [71:0] e,
                     input logic [71:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // Watch outputs off the edge; any set with no note is a mismatch
  always @(negedge hclk)
  begin
    if (underrun_evt === 1'h1) uf++;
    if (ai_start === 1'h1) ai++;
    if (ao_update === 1'h1)
    begin
      if (exp_q.size() == 0) chk("spare set", 72'h1, 72'h0);
      else chk("set", exp_q.pop_front(), {ao0, ao1, dout});
      chk("lamp", 72'h1, {71'h0, led_green & !led_amber});
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'h1, a, d, q);
  endtask
  // Reference ticks up to the next set, bounded
  task automatic wait_upd(output int t);
    t = 0;
    repeat (40000)
    begin
      @(negedge hclk);
      if (ref_tick === 1'h1) t++;
      if (ao_update === 1'h1) return;
    end
    chk("set wait", 72'h1, 72'h0);
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #600000;
    bad_count++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(73));
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(negedge hclk);
    chk("reset", {dac_seq_pkg::MID_CODE, dac_seq_pkg::MID_CODE, 8'h0},
        {ao0, ao1, dout});
    for (int c = 0; c < 2; c++)
    begin
      v = $urandom();
      wr(dac_seq_pkg::CTRL_OFS, {22'h0, c[1:0], 8'h2});
      wr(dac_seq_pkg::SVAL_OFS, v);
      wr(dac_seq_pkg::CMD_OFS, 32'h10);
      @(negedge hclk);
      chk("single", {40'h0, v}, {40'h0, c == 0 ? ao0 : ao1});
    end
    for (int i = 0; i < 4; i++) w.push_back($urandom());
    host_u.load(w);
    wr(dac_seq_pkg::CTRL_OFS, 32'h5);
    wr(dac_seq_pkg::DIV_OFS, 32'h0);
    wr(dac_seq_pkg::CMD_OFS, 32'h1);
    repeat (2)
    begin
      exp_q.push_back({w[0], w[1], 8'h0});
      exp_q.push_back({w[2], w[3], 8'h0});
    end
    wr(dac_seq_pkg::CMD_OFS, 32'h2);
    wait_upd(n);
    chk("delay", 72'h1, {71'h0, n >= 35 * 223 && n <= 36 * 223 + 2});
    repeat (3) wait_upd(n);
    wr(dac_seq_pkg::CMD_OFS, 32'h8);
    wr(dac_seq_pkg::CMD_OFS, 32'h2);
    repeat (2000) @(negedge hclk);
    host_u.xfer(1'h0, dac_seq_pkg::STATUS_OFS, 32'h0, v);
    chk("halt", 72'h6, {69'h0, v[2:0]});
    wr(dac_seq_pkg::CMD_OFS, 32'h20);
    w = {$urandom(), $urandom(), $urandom()};
    host_u.load(w);
    wr(dac_seq_pkg::CTRL_OFS, 32'h86);
    exp_q.push_back({w[0], w[1], w[2][7:0]});
    wr(dac_seq_pkg::CMD_OFS, 32'h1);
    wr(dac_seq_pkg::CMD_OFS, 32'h2);
    wait_upd(n);
    repeat (2000) @(negedge hclk);
    host_u.xfer(1'h0, dac_seq_pkg::STATUS_OFS, 32'h0, v);
    chk("underrun", 72'hE, {67'h0, v[4:0]});
    chk("underrun events", 72'h1, 72'(uf));
    chk("joint start", 72'h1, 72'(ai));
    host_u.xfer(1'h0, 8'h20, 32'h0, v);
    chk("unmapped", 72'h0, {40'h0, v});
    chk("response", 72'h0, {71'h0, hresp});
    end_of_test();
  end
endmodule // dac_output_sequencer_test
`default_nettype wire

// file: rtl/dac_output_sequencer.sv
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Channels 0,1 analog; slot 2 updates digital port
// - Analog samples are fixed 32-bit words
// - Pacing derived from shared 48 MHz reference
// - Sample rate clamped to 30..216 kHz
// - First output after 36 sample periods
// - Single value written at once, unpaced
// - Resident pattern fits the 64K-word memory
// - Whole sample set updates together per tick
// - Resident pattern wraps last-to-first until stopped
// - Large waveforms streamed by host after trigger
// - Repeat-one-buffer bit selects repeat or stream
// - Mute ramps to 0 V over 1020 samples
// - Stream mode runs gap-free, stops when empty
// - Empty queue during paced run flags underrun
// - Trigger lamp amber armed on a pin or sync bus (off for software trigger), green running, else off
// - Orderly stop finishes count, then ignores triggers
// - Abrupt stop halts at once, ignores triggers
// - One start can also start the input side
// - Output words are offset binary coded
// - Trigger source selectable; slave uses sync bus
// - Underrun reported as an event
module dac_output_sequencer #(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned DIO_W = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Reference tick and trigger inputs
  input wire logic ref_tick,
  input wire logic ext_trig,
  input wire logic sync_trig,
  // Converter and port outputs
  output logic [31:0] ao0,
  output logic [31:0] ao1,
  output logic [DIO_W-1:0] dout,
  output logic ao_update,
  // Events and indicators
  output logic underrun_evt,
  output logic ai_start,
  output logic led_amber,
  output logic led_green
);

  localparam int unsigned DEPTH = 1 << ADDR_W;
  localparam logic [ADDR_W:0] DEPTH_C = (ADDR_W+1)'(DEPTH);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic dp_ff; // Data phase pending, one wait state
  logic dp_write_ff;
  logic [7:0] dp_addr_ff;
  logic accept;
  logic wr_en;
  assign accept = hsel & htrans[1] & hready;
  assign wr_en = dp_ff & dp_write_ff;

  // Address phase capture; hsize is always a whole word here
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      dp_ff <= accept;
      hreadyout <= !accept;
      if (accept)
      begin
        dp_write_ff <= hwrite;
        dp_addr_ff <= haddr[7:0];
      end
    end
  end

  // Write decode helper used by every writable register
  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_en && (dp_addr_ff == ofs);
  endfunction

  // Software registers
  logic [dac_seq_pkg::CTL_W-1:0] ctrl_ff;
  logic [dac_seq_pkg::DIV_W-1:0] div_ff;
  logic [31:0] sval_ff;
  logic [31:0] stopcnt_ff;
  logic [5:0] cmd;
  assign cmd = hit(dac_seq_pkg::CMD_OFS) ? hwdata[5:0] : 6'h00;

  // Configuration writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ff <= dac_seq_pkg::CTL_RST;
      div_ff <= dac_seq_pkg::DIV_RST;
      sval_ff <= dac_seq_pkg::MID_CODE;
      stopcnt_ff <= 32'h0000_0000;
    end
    else
    begin
      if (hit(dac_seq_pkg::CTRL_OFS))
        ctrl_ff <= hwdata[dac_seq_pkg::CTL_W-1:0];
      if (hit(dac_seq_pkg::DIV_OFS))
        div_ff <= hwdata[dac_seq_pkg::DIV_W-1:0];
      if (hit(dac_seq_pkg::SVAL_OFS))
        sval_ff <= hwdata;
      if (hit(dac_seq_pkg::STOPCNT_OFS))
        stopcnt_ff <= hwdata;
    end
  end

  // Control fields
  logic repeat_one_buffer_select;
  logic [1:0] nch;
  logic [1:0] tsrc;
  logic slave_mode;
  logic mute;
  logic [1:0] single_ch;
  assign repeat_one_buffer_select = ctrl_ff[dac_seq_pkg::CTL_REPEAT];
  // A zero channel count is taken as one channel
  assign nch = (ctrl_ff[dac_seq_pkg::CTL_NCH_LO +: 2] == 2'h0) ? 2'h1 :
               ctrl_ff[dac_seq_pkg::CTL_NCH_LO +: 2];
  assign tsrc = ctrl_ff[dac_seq_pkg::CTL_TSRC_LO +: 2];
  assign slave_mode = ctrl_ff[dac_seq_pkg::CTL_SLAVE];
  assign mute = ctrl_ff[dac_seq_pkg::CTL_MUTE];
  assign single_ch = ctrl_ff[dac_seq_pkg::CTL_SCH_LO +: 2];

  // ****************************************************************
  // Pacing
  // ****************************************************************
  logic [dac_seq_pkg::DIV_W-1:0] div_eff;
  logic [dac_seq_pkg::DIV_W-1:0] pace_cnt_ff;
  logic pace_tick;
  assign div_eff =
    (div_ff < dac_seq_pkg::DIV_W'(dac_seq_pkg::DIV_MIN)) ?
      dac_seq_pkg::DIV_W'(dac_seq_pkg::DIV_MIN) :
    (div_ff > dac_seq_pkg::DIV_W'(dac_seq_pkg::DIV_MAX)) ?
      dac_seq_pkg::DIV_W'(dac_seq_pkg::DIV_MAX) : div_ff;
  assign pace_tick = ref_tick &&
                     (pace_cnt_ff == div_eff - 16'h0001);

  // free-running divider of the reference, never gated
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pace_cnt_ff <= 16'h0000;
    else if (pace_tick)
      pace_cnt_ff <= 16'h0000;
    else if (ref_tick)
      pace_cnt_ff <= pace_cnt_ff + 16'h0001;
  end

  // ****************************************************************
  // Triggers and sequencer
  // ****************************************************************
  logic ext_q_ff;
  logic sync_q_ff;
  logic trig_hit;
  dac_seq_pkg::seq_state_t state_ff;
  dac_seq_pkg::seq_state_t nxt_state;
  logic [5:0] delay_left_ff;
  logic stop_req_ff;
  logic [31:0] stop_left_ff;
  logic staged;
  logic update_now;
  logic underrun;

  // Edge history of the trigger pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_q_ff <= 1'b0;
      sync_q_ff <= 1'b0;
    end
    else
    begin
      ext_q_ff <= ext_trig;
      sync_q_ff <= sync_trig;
    end
  end

  // source select, slave forces sync bus
  always_comb
  begin
    if (slave_mode)
      trig_hit = sync_trig & !sync_q_ff;
    else
      case (tsrc)
        dac_seq_pkg::TSRC_SW: trig_hit = cmd[dac_seq_pkg::CMD_START];
        dac_seq_pkg::TSRC_RISE: trig_hit = ext_trig & !ext_q_ff;
        dac_seq_pkg::TSRC_FALL: trig_hit = !ext_trig & ext_q_ff;
        default: trig_hit = sync_trig & !sync_q_ff;
      endcase
  end

  // first update on the 36th tick after the trigger
  assign update_now = pace_tick &&
    ((state_ff == dac_seq_pkg::ST_RUN) ||
     (state_ff == dac_seq_pkg::ST_DELAY && delay_left_ff == 6'h01));
  // nothing staged when the tick comes
  assign underrun = update_now && !staged &&
    !(stop_req_ff && stop_left_ff == 32'h0000_0000);

  // Next state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      dac_seq_pkg::ST_IDLE, dac_seq_pkg::ST_HALT:
        if (cmd[dac_seq_pkg::CMD_ARM])
          nxt_state = dac_seq_pkg::ST_ARMED;
      dac_seq_pkg::ST_ARMED:
        if (trig_hit)
          nxt_state = dac_seq_pkg::ST_DELAY;
      dac_seq_pkg::ST_DELAY, dac_seq_pkg::ST_RUN:
        // orderly stop after the counted samples
        if (update_now && stop_req_ff &&
            stop_left_ff == 32'h0000_0000)
          nxt_state = dac_seq_pkg::ST_HALT;
        // stream ends when data runs out
        else if (underrun)
          nxt_state = dac_seq_pkg::ST_HALT;
        else if (update_now)
          nxt_state = dac_seq_pkg::ST_RUN;
      default:
        nxt_state = dac_seq_pkg::ST_IDLE;
    endcase
    if (cmd[dac_seq_pkg::CMD_ABRUPT] &&
        state_ff != dac_seq_pkg::ST_IDLE)
      nxt_state = dac_seq_pkg::ST_HALT;
  end

  // State, start delay and stop counters
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= dac_seq_pkg::ST_IDLE;
      delay_left_ff <= 6'h00;
      stop_req_ff <= 1'b0;
      stop_left_ff <= 32'h0000_0000;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == dac_seq_pkg::ST_ARMED)
        delay_left_ff <= dac_seq_pkg::START_DELAY;
      else if (pace_tick && delay_left_ff != 6'h00)
        delay_left_ff <= delay_left_ff - 6'h01;
      if (cmd[dac_seq_pkg::CMD_ARM])
        stop_req_ff <= 1'b0;
      else if (cmd[dac_seq_pkg::CMD_ORDERLY])
      begin
        stop_req_ff <= 1'b1;
        stop_left_ff <= stopcnt_ff;
      end
      else if (update_now && stop_req_ff &&
               stop_left_ff != 32'h0000_0000)
        stop_left_ff <= stop_left_ff - 32'h0000_0001;
    end
  end

  // ****************************************************************
  // Sample memory and fetch
  // ****************************************************************
  logic [31:0] mem [DEPTH]; // 64K-word output memory
  logic [31:0] mem_q_ff;
  logic [ADDR_W-1:0] wr_ptr_ff;
  logic [ADDR_W-1:0] rd_ptr_ff;
  logic [ADDR_W:0] fill_ff;
  logic [1:0] slot_ff;
  logic pend_ff;
  logic [1:0] pend_slot_ff;
  logic [31:0] stage_ff [3];
  logic push;
  logic issue;
  logic pop;
  logic fetch_on;
  // Full memory refuses further words silently
  assign push = hit(dac_seq_pkg::DATA_OFS) && fill_ff != DEPTH_C;
  assign fetch_on = (state_ff == dac_seq_pkg::ST_DELAY) ||
                    (state_ff == dac_seq_pkg::ST_RUN);
  // repeat mode never consumes, stream mode needs a word
  assign issue = fetch_on && slot_ff < nch && !update_now &&
    (repeat_one_buffer_select ? fill_ff != '0 : fill_ff != '0);
  assign pop = issue && !repeat_one_buffer_select;
  assign staged = (slot_ff == nch) && !pend_ff;

  // Memory write port and registered read port
  always_ff @(posedge hclk)
  begin
    if (push)
      mem[wr_ptr_ff] <= hwdata;
    mem_q_ff <= mem[rd_ptr_ff];
  end

  // Pointers, fill level and staging of one sample set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      fill_ff <= '0;
      slot_ff <= 2'h0;
      pend_ff <= 1'b0;
      pend_slot_ff <= 2'h0;
      for (int i = 0; i < 3; i++)
        stage_ff[i] <= dac_seq_pkg::MID_CODE;
    end
    else if (cmd[dac_seq_pkg::CMD_CLEAR] ||
             cmd[dac_seq_pkg::CMD_ARM])
    begin
      if (cmd[dac_seq_pkg::CMD_CLEAR])
      begin
        wr_ptr_ff <= '0;
        fill_ff <= '0;
      end
      rd_ptr_ff <= cmd[dac_seq_pkg::CMD_CLEAR] ? '0 :
        (repeat_one_buffer_select ? '0 : rd_ptr_ff);
      slot_ff <= 2'h0;
      pend_ff <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      fill_ff <= fill_ff + (ADDR_W+1)'(push) - (ADDR_W+1)'(pop);
      pend_ff <= issue;
      if (issue)
      begin
        pend_slot_ff <= slot_ff;
        slot_ff <= slot_ff + 2'h1;
        // wrap from last loaded word back to the first
        if (repeat_one_buffer_select &&
            rd_ptr_ff == wr_ptr_ff - 1'b1)
          rd_ptr_ff <= '0;
        else
          rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (pend_ff)
        stage_ff[pend_slot_ff] <= mem_q_ff;
      if (update_now)
        slot_ff <= 2'h0;
    end
  end

  // ****************************************************************
  // Mute ramp and outputs
  // ****************************************************************
  logic [10:0] gain_ff;

  // linear scaling about the 0 V code
  function automatic logic [31:0] scale(input logic [31:0] s,
                                        input logic [10:0] g);
    logic signed [32:0] diff;
    logic signed [45:0] prod;
    diff = $signed({1'b0, s}) - $signed({1'b0, dac_seq_pkg::MID_CODE});
    prod = diff * $signed({1'b0, g});
    prod = prod / $signed({35'h0, dac_seq_pkg::RAMP_STEPS});
    scale = dac_seq_pkg::MID_CODE + prod[31:0];
  endfunction

  // one ramp step per paced sample
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gain_ff <= dac_seq_pkg::RAMP_STEPS;
    else if (update_now && !underrun)
    begin
      if (mute && gain_ff != 11'h000)
        gain_ff <= gain_ff - 11'h001;
      else if (!mute && gain_ff != dac_seq_pkg::RAMP_STEPS)
        gain_ff <= gain_ff + 11'h001;
    end
  end

  // all channels of a set change on the same edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ao0 <= dac_seq_pkg::MID_CODE;
      ao1 <= dac_seq_pkg::MID_CODE;
      dout <= '0;
      ao_update <= 1'b0;
    end
    else
    begin
      ao_update <= update_now && staged;
      if (update_now && staged)
      begin
        // slot 2 drives the digital port, not muted
        ao0 <= scale(stage_ff[0], gain_ff);
        if (nch > 2'h1)
          ao1 <= scale(stage_ff[1], gain_ff);
        if (nch > 2'h2)
          dout <= stage_ff[2][DIO_W-1:0];
      end
      else if (cmd[dac_seq_pkg::CMD_SINGLE])
      begin
        case (single_ch)
          2'h0: ao0 <= sval_ff;
          2'h1: ao1 <= sval_ff;
          2'h2: dout <= sval_ff[DIO_W-1:0];
          default: ao0 <= ao0;
        endcase
      end
    end
  end

  // ****************************************************************
  // Events, lamp, status readback
  // ****************************************************************
  logic underrun_st_ff;
  logic clr_underrun;
  assign clr_underrun = hit(dac_seq_pkg::STATUS_OFS) &&
                        hwdata[dac_seq_pkg::ST_UNDERRUN];

  // pulse plus sticky flag, a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      underrun_evt <= 1'b0;
      underrun_st_ff <= 1'b0;
      ai_start <= 1'b0;
      led_amber <= 1'b0;
      led_green <= 1'b0;
    end
    else
    begin
      underrun_evt <= underrun;
      if (underrun)
        underrun_st_ff <= 1'b1;
      else if (clr_underrun)
        underrun_st_ff <= 1'b0;
      // shared start for the input side
      ai_start <= cmd[dac_seq_pkg::CMD_START] &&
                  ctrl_ff[dac_seq_pkg::CTL_SIMUL];
      // amber only when waiting on a pin or the sync bus
      led_amber <= state_ff == dac_seq_pkg::ST_ARMED &&
                   (slave_mode || tsrc != dac_seq_pkg::TSRC_SW);
      led_green <= fetch_on;
    end
  end

  // Read data loaded during the wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (dp_ff && !dp_write_ff)
      case (dp_addr_ff)
        dac_seq_pkg::CTRL_OFS: hrdata <= 32'(ctrl_ff);
        dac_seq_pkg::DIV_OFS: hrdata <= 32'(div_ff);
        dac_seq_pkg::SVAL_OFS: hrdata <= sval_ff;
        dac_seq_pkg::STOPCNT_OFS: hrdata <= stopcnt_ff;
        dac_seq_pkg::STATUS_OFS:
          hrdata <= {27'h0, staged, underrun_st_ff, state_ff};
        dac_seq_pkg::FILL_OFS: hrdata <= 32'(fill_ff);
        default: hrdata <= 32'h0000_0000;
      endcase
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence wait_then_ready_s;
    !hreadyout ##1 hreadyout;
  endsequence
  bus_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    accept |=> wait_then_ready_s) else $error("bus wait state wrong");
  pace_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    div_eff >= 16'd223 && div_eff <= 16'd1600)
    else $error("pacing divisor out of range");
  sequence trig_s;
    state_ff == dac_seq_pkg::ST_ARMED && trig_hit;
  endsequence
  start_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    trig_s |=> delay_left_ff == dac_seq_pkg::START_DELAY ##1
      delay_left_ff >= dac_seq_pkg::START_DELAY - 6'h01)
    else $error("start delay not loaded");
  first_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == dac_seq_pkg::ST_DELAY |-> !update_now ||
      delay_left_ff == 6'd1) else $error("early first output");
  single_val_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd[dac_seq_pkg::CMD_SINGLE] && !update_now && single_ch == 2'h0
    |=> ao0 == $past(sval_ff)) else $error("single value not driven");
  update_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ao_update |-> $past(pace_tick) && $past(fetch_on))
    else $error("update off the pacing tick");
  ramp_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    update_now && !underrun && mute && gain_ff != 11'd0
    |=> gain_ff == $past(gain_ff) - 11'd1) else $error("ramp step wrong");
  underrun_a: assert property (@(posedge hclk) disable iff (!hresetn)
    underrun |=> underrun_evt && underrun_st_ff &&
      state_ff == dac_seq_pkg::ST_HALT) else $error("underrun unreported");
  halt_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == dac_seq_pkg::ST_HALT && !cmd[dac_seq_pkg::CMD_ARM]
    |=> state_ff == dac_seq_pkg::ST_HALT) else $error("trigger not ignored");
  abrupt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd[dac_seq_pkg::CMD_ABRUPT] && fetch_on
    |=> state_ff == dac_seq_pkg::ST_HALT ##1 !ao_update)
    else $error("abrupt stop late");
  lamp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 led_green == $past(fetch_on) && !(led_green && led_amber))
    else $error("lamp state wrong");

endmodule // dac_output_sequencer
`default_nettype wire

// file: rtl/dac_seq_pkg.sv
package dac_seq_pkg;

  // ****************************************************************
  // Pacing and timing
  // ****************************************************************
  // Shared reference rate and legal output sample rates
  localparam int unsigned REF_HZ = 48_000_000;
  localparam int unsigned FS_MIN_HZ = 30_000;
  localparam int unsigned FS_MAX_HZ = 216_000;
  // Least divisor rounds up so the rate never exceeds the maximum
  localparam int unsigned DIV_MIN = (REF_HZ + FS_MAX_HZ - 1) / FS_MAX_HZ;
  // Largest divisor rounds down so the rate never drops below minimum
  localparam int unsigned DIV_MAX = REF_HZ / FS_MIN_HZ;
  localparam int unsigned DIV_W = 16;
  // Sample periods from trigger to the first converted output
  localparam logic [5:0] START_DELAY = 6'h24;
  // Samples in a mute or unmute ramp
  localparam logic [10:0] RAMP_STEPS = 11'h3FC;
  // Offset binary code of 0 V
  localparam logic [31:0] MID_CODE = 32'h8000_0000;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] DIV_OFS = 8'h08;
  localparam logic [7:0] SVAL_OFS = 8'h0C;
  localparam logic [7:0] STOPCNT_OFS = 8'h10;
  localparam logic [7:0] DATA_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] FILL_OFS = 8'h1C;

  // Control field positions
  localparam int unsigned CTL_REPEAT = 0;
  localparam int unsigned CTL_NCH_LO = 1;
  localparam int unsigned CTL_TSRC_LO = 3;
  localparam int unsigned CTL_SLAVE = 5;
  localparam int unsigned CTL_MUTE = 6;
  localparam int unsigned CTL_SIMUL = 7;
  localparam int unsigned CTL_SCH_LO = 8;
  localparam int unsigned CTL_W = 10;
  localparam logic [CTL_W-1:0] CTL_RST = 10'h002;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0640;

  // Command bits, self clearing
  localparam int unsigned CMD_ARM = 0;
  localparam int unsigned CMD_START = 1;
  localparam int unsigned CMD_ORDERLY = 2;
  localparam int unsigned CMD_ABRUPT = 3;
  localparam int unsigned CMD_SINGLE = 4;
  localparam int unsigned CMD_CLEAR = 5;

  // Status bits
  localparam int unsigned ST_UNDERRUN = 3;
  localparam int unsigned ST_STAGED = 4;

  // Trigger sources
  localparam logic [1:0] TSRC_SW = 2'h0;
  localparam logic [1:0] TSRC_RISE = 2'h1;
  localparam logic [1:0] TSRC_FALL = 2'h2;
  localparam logic [1:0] TSRC_SYNC = 2'h3;

  // Sequencer states, Gray coded along idle-armed-delay-run-halt
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARMED = 3'h1,
    ST_DELAY = 3'h3,
    ST_RUN = 3'h2,
    ST_HALT = 3'h6
  } seq_state_t;

endpackage
